/* File: core/itr_dev_end.sv */
`timescale 1ns/1ps
`include "itr_defs.svh"
// Contract
// - serve only while enable high, also low-power
// - handle two-wire transfers up to 400 kbps
// - first byte after start is address
// - match 010110 plus strap bit
// - strap selects 0x5A/0x5B or 0x58/0x59
// - direction bit zero write, one read
// - acknowledge matching address, both directions
// - write: acknowledge one subaddress byte, MSB first
// - acknowledge and store every written data byte
// - master ends write with stop
// - read MSB first from pointer, reset 00h
// - sample master ack, continue only on ack
// - master acks each read byte except last
// - master ends read with stop
// - address plus subaddress write sets read start
// - master never alters reserved register fields
module itr_dev_end (
  input  logic        clk,
  input  logic        srst,
  itr_if.dev          bus,
  input  logic        enPin,
  input  logic        addrSelPin,
  input  logic [7:0]  rdData,
  output logic        wrStb_q,
  output logic [7:0]  wrAddr_q,
  output logic [7:0]  wrData_q,
  output logic [7:0]  rdAddr_q,
  output logic        busy_q
);

  // ----------------------------------------
  // synchronisers and edge history
  // ----------------------------------------
  logic sclMeta_q, sclSync_q, sclPrev_q;
  logic sdaMeta_q, sdaSync_q, sdaPrev_q;
  logic enMeta_q, enSync_q;
  logic selMeta_q, selSync_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      enMeta_q  <= 1'b0;
      enSync_q  <= 1'b0;
      selMeta_q <= 1'b0;
      selSync_q <= 1'b0;
    end else begin
      sclMeta_q <= bus.scl;
      sclSync_q <= sclMeta_q;
      sclPrev_q <= sclSync_q;
      sdaMeta_q <= bus.sda;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
      enMeta_q  <= enPin;
      enSync_q  <= enMeta_q;
      selMeta_q <= addrSelPin;
      selSync_q <= selMeta_q;
    end
  end

  // ----------------------------------------
  // bus conditions
  // ----------------------------------------
  logic sclRise, sclFall, startC, stopC;

  assign sclRise = sclSync_q & !sclPrev_q;
  assign sclFall = !sclSync_q & sclPrev_q;
  assign startC  = sclSync_q & sclPrev_q & sdaPrev_q & !sdaSync_q;
  assign stopC   = sclSync_q & sclPrev_q & !sdaPrev_q & sdaSync_q;

  // ----------------------------------------
  // transfer engine
  // ----------------------------------------
  itr_pkg::itr_dstate_e state_q;
  itr_pkg::itr_kind_e   kind_q;
  logic [3:0]           bitCnt_q;
  logic [7:0]           shift_q;
  logic                 rw_q;
  logic                 strap_q;
  logic                 sdaOe_q;
  logic                 sdaOut_q;
  logic [7:0]           ptr_q;
  logic [7:0]           base_q;

  assign rdAddr_q   = ptr_q;
  assign bus.sdaOeD = sdaOe_q;
  assign bus.sdaOutD = sdaOut_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q  <= itr_pkg::D_IDLE;
      kind_q   <= itr_pkg::K_ADDR;
      bitCnt_q <= 4'h0;
      shift_q  <= 8'h00;
      rw_q     <= `ITR_RW_WRITE;
      strap_q  <= 1'b0;
      sdaOe_q  <= 1'b0;
      sdaOut_q <= 1'b0;
      ptr_q    <= `ITR_PTR_RST;
      base_q   <= `ITR_PTR_RST;
      wrStb_q  <= 1'b0;
      wrAddr_q <= 8'h00;
      wrData_q <= 8'h00;
      busy_q   <= 1'b0;
    end else begin
      wrStb_q <= 1'b0;
      if (!enSync_q) begin
        state_q <= itr_pkg::D_IDLE;
        sdaOe_q <= 1'b0;
        busy_q  <= 1'b0;
      end else if (startC) begin
        state_q  <= itr_pkg::D_RXB;
        kind_q   <= itr_pkg::K_ADDR;
        bitCnt_q <= 4'h0;
        sdaOe_q  <= 1'b0;
        strap_q  <= selSync_q;
        busy_q   <= 1'b1;
      end else if (stopC) begin
        state_q <= itr_pkg::D_IDLE;
        sdaOe_q <= 1'b0;
        busy_q  <= 1'b0;
      end else begin
        case (state_q)
          itr_pkg::D_RXB: begin
            if (sclRise) begin
              shift_q  <= {shift_q[6:0], sdaSync_q};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == `ITR_BYTE_BITS) begin
              bitCnt_q <= 4'h0;
              case (kind_q)
                itr_pkg::K_ADDR: begin
                  if (shift_q[7:1] == {`ITR_ADDR_HI, strap_q}) begin
                    sdaOe_q <= 1'b1;
                    rw_q    <= shift_q[0];
                    if (shift_q[0]) ptr_q <= base_q;
                    kind_q  <= shift_q[0] ? itr_pkg::K_DATA : itr_pkg::K_SUB;
                    state_q <= itr_pkg::D_ACK;
                  end else begin
                    state_q <= itr_pkg::D_WAIT;
                  end
                end
                itr_pkg::K_SUB: begin
                  ptr_q   <= shift_q;
                  base_q  <= shift_q;
                  kind_q  <= itr_pkg::K_DATA;
                  sdaOe_q <= 1'b1;
                  state_q <= itr_pkg::D_ACK;
                end
                default: begin
                  wrStb_q  <= 1'b1;
                  wrAddr_q <= ptr_q;
                  wrData_q <= shift_q;
                  ptr_q    <= ptr_q + 8'h01;
                  sdaOe_q  <= 1'b1;
                  state_q  <= itr_pkg::D_ACK;
                end
              endcase
            end
          end
          itr_pkg::D_ACK: begin
            if (sclFall) begin
              if (rw_q == `ITR_RW_READ) begin
                shift_q  <= rdData;
                sdaOe_q  <= !rdData[7];
                bitCnt_q <= 4'h1;
                state_q  <= itr_pkg::D_TXB;
              end else begin
                sdaOe_q  <= 1'b0;
                bitCnt_q <= 4'h0;
                state_q  <= itr_pkg::D_RXB;
              end
            end
          end
          itr_pkg::D_TXB: begin
            if (sclFall) begin
              if (bitCnt_q == `ITR_BYTE_BITS) begin
                sdaOe_q <= 1'b0;
                ptr_q   <= ptr_q + 8'h01;
                state_q <= itr_pkg::D_RXACK;
              end else begin
                sdaOe_q  <= !shift_q[6];
                shift_q  <= {shift_q[6:0], 1'b0};
                bitCnt_q <= bitCnt_q + 4'h1;
              end
            end
          end
          itr_pkg::D_RXACK: begin
            if (sclRise) begin
              state_q <= sdaSync_q ? itr_pkg::D_WAIT : itr_pkg::D_ACK;
            end
          end
          itr_pkg::D_WAIT: begin
            sdaOe_q <= 1'b0;
          end
          default: begin
            sdaOe_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

/* File: pkg/itr_defs.svh */
`ifndef ITR_DEFS_SVH
`define ITR_DEFS_SVH

// ----------------------------------------
// target address and pointer reset
// ----------------------------------------
`define ITR_ADDR_HI   6'h16
`define ITR_PTR_RST   8'h00
`define ITR_RW_WRITE  1'b0
`define ITR_RW_READ   1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define ITR_CLK_NS    100
`define ITR_BIT_NS    2500
`define ITR_QTR_CYC   (`ITR_BIT_NS / (4 * `ITR_CLK_NS))
`define ITR_BYTE_BITS 4'h8

`endif

/* File: pkg/itr_pkg.sv */
package itr_pkg;

  // ----------------------------------------
  // target end states
  // ----------------------------------------
  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_RXB   = 3'h1,
    D_ACK   = 3'h3,
    D_TXB   = 3'h2,
    D_RXACK = 3'h6,
    D_WAIT  = 3'h7
  } itr_dstate_e;

  // ----------------------------------------
  // master end states
  // ----------------------------------------
  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_BIT   = 2'h3,
    H_STOP  = 2'h2
  } itr_hstate_e;

  // ----------------------------------------
  // byte kind within a transfer
  // ----------------------------------------
  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_SUB  = 2'h1,
    K_DATA = 2'h3
  } itr_kind_e;

endpackage

/* File: pkg/itr_if.sv */
`timescale 1ns/1ps
interface itr_if;
  logic sclOutH;
  logic sclOeH;
  logic sdaOutH;
  logic sdaOeH;
  logic sdaOutD;
  logic sdaOeD;
  logic scl;
  logic sda;

  // ----------------------------------------
  // open-drain wire levels
  // ----------------------------------------
  assign scl = !(sclOeH & !sclOutH);
  assign sda = !((sdaOeH & !sdaOutH) | (sdaOeD & !sdaOutD));

  modport host (output sclOutH, output sclOeH, output sdaOutH, output sdaOeH, input scl, input sda);
  modport dev  (output sdaOutD, output sdaOeD, input scl, input sda);
endinterface

/* File: core/itr_host_end.sv */
`timescale 1ns/1ps
`include "itr_defs.svh"
module itr_host_end (
  input  logic        clk,
  input  logic        srst,
  itr_if.host         bus,
  input  logic        devAddrBit,
  input  logic        cmdValid,
  input  logic        cmdRead,
  input  logic [7:0]  cmdLen,
  input  logic [7:0]  cmdSub,
  input  logic [7:0]  wrData,
  output logic        cmdReady_q,
  output logic        wrTake_q,
  output logic [7:0]  rdData_q,
  output logic        rdValid_q,
  output logic        done_q,
  output logic        nack_q
);

  // ----------------------------------------
  // data line synchroniser
  // ----------------------------------------
  logic sdaMeta_q, sdaSync_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
    end else begin
      sdaMeta_q <= bus.sda;
      sdaSync_q <= sdaMeta_q;
    end
  end

  // ----------------------------------------
  // quarter-bit divider
  // ----------------------------------------
  localparam logic [2:0] QTR_LAST = 3'(`ITR_QTR_CYC - 1);
  itr_pkg::itr_hstate_e state_q;
  logic [2:0]           div_q;
  logic                 tick;

  assign tick = (div_q == QTR_LAST);

  always_ff @(posedge clk) begin
    if (srst || state_q == itr_pkg::H_IDLE || tick) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  itr_pkg::itr_kind_e kind_q;
  logic [1:0]         qtr_q;
  logic [3:0]         bitIdx_q;
  logic [7:0]         txSh_q, rxSh_q, left_q;
  logic               rd_q, ackOk_q, sclLow_q, sdaLow_q;

  assign bus.sclOutH = 1'b0;
  assign bus.sdaOutH = 1'b0;
  assign bus.sclOeH  = sclLow_q;
  assign bus.sdaOeH  = sdaLow_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= itr_pkg::H_IDLE;
      kind_q <= itr_pkg::K_ADDR;
      qtr_q <= 2'h0;
      bitIdx_q <= 4'h0;
      txSh_q <= 8'hFF;
      rxSh_q <= 8'h00;
      left_q <= 8'h00;
      rd_q <= 1'b0;
      ackOk_q <= 1'b0;
      sclLow_q <= 1'b0;
      sdaLow_q <= 1'b0;
      cmdReady_q <= 1'b0;
      wrTake_q <= 1'b0;
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      wrTake_q <= 1'b0;
      rdValid_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        itr_pkg::H_IDLE: begin
          sclLow_q <= 1'b0;
          sdaLow_q <= 1'b0;
          cmdReady_q <= !(cmdValid && cmdReady_q);
          if (cmdValid && cmdReady_q) begin
            txSh_q <= {`ITR_ADDR_HI, devAddrBit, cmdRead};
            rd_q <= cmdRead;
            left_q <= (cmdRead && cmdLen == 8'h00) ? 8'h01 : cmdLen;
            kind_q <= itr_pkg::K_ADDR;
            nack_q <= 1'b0;
            qtr_q <= 2'h0;
            state_q <= itr_pkg::H_START;
          end
        end
        itr_pkg::H_START: begin
          if (tick) begin
            qtr_q <= qtr_q + 2'h1;
            if (qtr_q == 2'h0) sdaLow_q <= 1'b1;
            if (qtr_q == 2'h1) sclLow_q <= 1'b1;
            if (qtr_q == 2'h2) begin
              qtr_q <= 2'h0;
              bitIdx_q <= 4'h0;
              state_q <= itr_pkg::H_BIT;
            end
          end
        end
        itr_pkg::H_BIT: begin
          if (tick) begin
            qtr_q <= qtr_q + 2'h1;
            case (qtr_q)
              2'h0: begin
                sclLow_q <= 1'b1;
                if (bitIdx_q != `ITR_BYTE_BITS) sdaLow_q <= !txSh_q[7];
                else sdaLow_q <= rd_q && kind_q == itr_pkg::K_DATA && left_q != 8'h01;
              end
              2'h1: sclLow_q <= 1'b0;
              2'h2: begin
                if (bitIdx_q != `ITR_BYTE_BITS) rxSh_q <= {rxSh_q[6:0], sdaSync_q};
                else ackOk_q <= !sdaSync_q;
              end
              default: begin
                sclLow_q <= 1'b1;
                if (bitIdx_q != `ITR_BYTE_BITS) begin
                  txSh_q <= {txSh_q[6:0], 1'b1};
                  bitIdx_q <= bitIdx_q + 4'h1;
                end else begin
                  bitIdx_q <= 4'h0;
                  txSh_q <= 8'hFF;
                  if (rd_q && kind_q == itr_pkg::K_DATA) begin
                    rdData_q <= rxSh_q;
                    rdValid_q <= 1'b1;
                    left_q <= left_q - 8'h01;
                    if (left_q == 8'h01) state_q <= itr_pkg::H_STOP;
                  end else if (!ackOk_q) begin
                    nack_q <= 1'b1;
                    state_q <= itr_pkg::H_STOP;
                  end else if (kind_q == itr_pkg::K_ADDR && rd_q) begin
                    kind_q <= itr_pkg::K_DATA;
                  end else if (kind_q == itr_pkg::K_ADDR) begin
                    kind_q <= itr_pkg::K_SUB;
                    txSh_q <= cmdSub;
                  end else if (left_q == 8'h00) begin
                    state_q <= itr_pkg::H_STOP;
                  end else begin
                    kind_q <= itr_pkg::K_DATA;
                    txSh_q <= wrData;
                    wrTake_q <= 1'b1;
                    left_q <= left_q - 8'h01;
                  end
                end
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            qtr_q <= qtr_q + 2'h1;
            case (qtr_q)
              2'h0: sdaLow_q <= 1'b1;
              2'h1: sclLow_q <= 1'b0;
              2'h2: sdaLow_q <= 1'b0;
              default: begin
                done_q <= 1'b1;
                state_q <= itr_pkg::H_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

endmodule

/* File: sim/itr_asserts.sv */
`timescale 1ns/1ps
module itr_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclOutH,
  input wire logic sclOeH,
  input wire logic sdaOutH,
  input wire logic sdaOeH,
  input wire logic sdaOutD,
  input wire logic sdaOeD,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------
  // wire checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !sdaOeD)
    else $error("device drives data line after reset");
  a_start_by_host: assert property (scl && $past(scl) && $fell(sda) |-> sdaOeH && !sdaOeD)
    else $error("start not made by master");
  a_stop_release: assert property (scl && $past(scl) && $rose(sda) |-> !sdaOeD)
    else $error("device holds data line at stop");
  a_scl_high_min: assert property ($rose(scl) |-> scl[*5])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl[*5])
    else $error("clock low phase too short");
  a_dev_low_only: assert property ($changed(sdaOeD) |-> !scl)
    else $error("device changes data while clock high");
  a_ack_window: assert property ($rose(sdaOeD) |-> !scl[*6])
    else $error("device drive starts late in low phase");
  a_drive_bound: assert property ($rose(sdaOeD) |-> ##[1:240] !sdaOeD)
    else $error("device holds data line too long");
endmodule

/* File: sim/tb_i2c_target_register_access.sv */
`timescale 1ns/1ps
module tb_i2c_target_register_access;
  logic       clk, srst, enPin, addrSelPin, devAddrBit, cmdValid, cmdRead;
  logic [7:0] cmdLen, cmdSub, wrData, rdData, wrAddr, wrDataD, rdAddr, rdDataH;
  logic       wrStb, busy, cmdReady, wrTake, rdValid, done, nack;
  logic [7:0] regMem [256];
  logic [7:0] wrBuf  [4];
  logic [7:0] rdQ    [$];
  int         wrIdx, badCount, checkCount;

  itr_if bus ();
  itr_dev_end u_itr_dev_end (.clk(clk), .srst(srst), .bus(bus.dev), .enPin(enPin), .addrSelPin(addrSelPin),
    .rdData(rdData), .wrStb_q(wrStb), .wrAddr_q(wrAddr), .wrData_q(wrDataD), .rdAddr_q(rdAddr), .busy_q(busy));
  itr_host_end u_itr_host_end (.clk(clk), .srst(srst), .bus(bus.host), .devAddrBit(devAddrBit),
    .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdLen(cmdLen), .cmdSub(cmdSub), .wrData(wrData),
    .cmdReady_q(cmdReady), .wrTake_q(wrTake), .rdData_q(rdDataH), .rdValid_q(rdValid), .done_q(done), .nack_q(nack));
  itr_asserts u_itr_asserts (.clk(clk), .srst(srst), .sclOutH(bus.sclOutH), .sclOeH(bus.sclOeH),
    .sdaOutH(bus.sdaOutH), .sdaOeH(bus.sdaOeH), .sdaOutD(bus.sdaOutD), .sdaOeD(bus.sdaOeD),
    .scl(bus.scl), .sda(bus.sda));

  // ----------------------------------------
  // clock, register file, capture
  // ----------------------------------------
  always #50 clk = ~clk;
  assign rdData = regMem[rdAddr];
  always @(posedge clk) begin
    if (wrStb) regMem[wrAddr] <= wrDataD;
    if (rdValid) rdQ.push_back(rdDataH);
    if (wrTake) wrIdx <= wrIdx + 1;
    wrData <= wrBuf[wrIdx[1:0]];
  end

  function automatic logic [7:0] patt(input logic [7:0] a);
    return a ^ 8'hC3;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic runCmd(input logic rd, input logic [7:0] len, input logic [7:0] sub);
    int n;
    wrIdx = 0;
    rdQ.delete();
    n = 0;
    while (cmdReady !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk) begin
      cmdValid <= 1'b1;
      cmdRead  <= rd;
      cmdLen   <= len;
      cmdSub   <= sub;
    end
    @(posedge clk) cmdValid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, done}, 8'h01);
    chk({7'h00, busy}, 8'h00);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic tReadReset();
    runCmd(1'b1, 8'h02, 8'h00);
    chk(rdQ[0], patt(8'h00));
    chk(rdQ[1], patt(8'h01));
  endtask

  task automatic tWriteBurst();
    int i;
    wrBuf = '{8'h11, 8'h22, 8'h33, 8'h44};
    runCmd(1'b0, 8'h03, 8'h10);
    for (i = 0; i < 3; i++) begin
      chk(regMem[8'h10 + i], wrBuf[i]);
    end
    chk({7'h00, nack}, 8'h00);
    chk(rdAddr, 8'h13);
    runCmd(1'b1, 8'h02, 8'h00);
    chk(rdQ[0], wrBuf[0]);
    chk(rdQ[1], wrBuf[1]);
  endtask

  task automatic tSetPtrRead();
    int i;
    runCmd(1'b0, 8'h00, 8'h20);
    chk(rdAddr, 8'h20);
    chk(regMem[8'h20], patt(8'h20));
    runCmd(1'b1, 8'h03, 8'h00);
    for (i = 0; i < 3; i++) begin
      chk(rdQ[i], patt(8'h20 + i));
    end
    chk(rdQ.size(), 8'h03);
  endtask

  task automatic tAddrMatch();
    int s, h;
    logic [7:0] a;
    for (s = 0; s < 2; s++) begin
      for (h = 0; h < 2; h++) begin
        a = 8'h40 + 8'(s * 2 + h);
        @(posedge clk) begin
          addrSelPin <= s[0];
          devAddrBit <= h[0];
        end
        wrBuf[0] = a ^ 8'hFF;
        runCmd(1'b0, 8'h01, a);
        chk({7'h00, nack}, {7'h00, s[0] ^ h[0]});
        chk(regMem[a], (s == h) ? wrBuf[0] : patt(a));
        runCmd(1'b1, 8'h01, 8'h00);
        chk({7'h00, nack}, {7'h00, s[0] ^ h[0]});
        if (s == h) chk(rdQ[0], wrBuf[0]);
      end
    end
    @(posedge clk) begin
      addrSelPin <= 1'b1;
      devAddrBit <= 1'b1;
    end
  endtask

  task automatic tDisabled();
    @(posedge clk) enPin <= 1'b0;
    repeat (4) @(posedge clk);
    wrBuf[0] = 8'hEE;
    runCmd(1'b0, 8'h01, 8'h50);
    chk({7'h00, nack}, 8'h01);
    chk(regMem[8'h50], patt(8'h50));
    @(posedge clk) enPin <= 1'b1;
    repeat (4) @(posedge clk);
    runCmd(1'b0, 8'h01, 8'h50);
    chk(regMem[8'h50], 8'hEE);
  endtask

  task automatic completeRun();
    if (badCount == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    enPin = 1'b1;
    addrSelPin = 1'b1;
    devAddrBit = 1'b1;
    cmdValid = 1'b0;
    cmdRead = 1'b0;
    cmdLen = 8'h00;
    cmdSub = 8'h00;
    wrData = 8'h00;
    wrIdx = 0;
    badCount = 0;
    checkCount = 0;
    wrBuf = '{8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 256; i++) regMem[i] = patt(8'(i));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    tReadReset();
    tWriteBurst();
    tSetPtrRead();
    tAddrMatch();
    tDisabled();
    completeRun();
  end

  initial begin
    #6000000;
    badCount++;
    completeRun();
  end
endmodule
